// File: rtl/standard_pwm_generator.sv
// Standard-mode PWM generator with three period timers and AHB-Lite registers
//
// The AHB-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ns
`include "pwm_defs.svh"
module standard_pwm_generator #(
  parameter int NT = 3,
  parameter int AW = 8
) (
  // Clock, reset, sleep gate
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          ce,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  // Output pin
  output logic               pwm_output_pin,
  output logic               pin_oe_n
);
  import pwm_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Bus front end
  logic          acc_wr;
  logic          acc_rd;
  logic [AW-1:0] acc_addr;
  logic [31:0]   rdata;
  logic          size_unused;
  assign size_unused = ^hsize;

  ahb_word_port #(.AW(AW)) u_port (
    .clk       (clk),
    .reset_n   (reset_n),
    .ce        (ce),
    .hsel      (hsel),
    .haddr     (haddr),
    .htrans    (htrans),
    .hwrite    (hwrite),
    .hready    (hready),
    .hreadyout (hreadyout),
    .hrdata    (hrdata),
    .hresp     (hresp),
    .acc_wr    (acc_wr),
    .acc_rd    (acc_rd),
    .acc_addr  (acc_addr),
    .rdata     (rdata)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [5:0]   control_reg;
  byte_t        staging_reg;
  byte_t        active_reg;
  logic [1:0]   latch_reg;
  logic [1:0]   tsel_reg;
  logic [6:0]   tcon_reg   [NT];
  byte_t        period_reg [NT];
  logic [NT-1:0] flag_reg;
  logic         dir_reg;

  logic         pwm_on;
  logic         wr_control;
  logic         wr_staging;
  logic         wr_active;
  logic         wr_tsel;
  logic         wr_flags;
  logic         wr_dir;
  logic [NT-1:0] wr_tcon;
  logic [NT-1:0] wr_period;
  logic [NT-1:0] wr_count;

  assign pwm_on     = control_reg[`FLD_MODE_HI:`FLD_MODE_LO] == `MODE_PWM_CODE;
  assign wr_control = acc_wr && (acc_addr == `OFS_MODULE_CONTROL);
  assign wr_staging = acc_wr && (acc_addr == `OFS_DUTY_STAGING);
  assign wr_active  = acc_wr && (acc_addr == `OFS_ACTIVE_DUTY);
  assign wr_tsel    = acc_wr && (acc_addr == `OFS_TIMER_SELECT);
  assign wr_flags   = acc_wr && (acc_addr == `OFS_IRQ_FLAGS);
  assign wr_dir     = acc_wr && (acc_addr == `OFS_PIN_DIRECTION);

  //////////////////////////////////////////////////////////////////////////////
  // Timers
  byte_t         count   [NT];
  logic [1:0]    phase   [NT];
  logic [NT-1:0] bnd;
  logic [NT-1:0] last;

  for (genvar i = 0; i < NT; i++) begin : g_timer
    assign wr_tcon[i]   = acc_wr && (acc_addr == `OFS_TIMER_CONTROL0 + AW'(i * 4));
    assign wr_period[i] = acc_wr && (acc_addr == `OFS_PERIOD0 + AW'(i * 4));
    assign wr_count[i]  = acc_wr && (acc_addr == `OFS_TIMER_COUNT0 + AW'(i * 4));
    // Postscaler bits 6:3 are stored only
    period_timer #(.CW(8)) u_timer (
      .clk         (clk),
      .reset_n     (reset_n),
      .ce          (ce),
      .run         (tcon_reg[i][`FLD_TIMER_RUN]),
      .prescale    (prescale_t'(tcon_reg[i][1:0])),
      .period      (period_reg[i]),
      .count_wr    (wr_count[i]),
      .count_wdata (hwdata[7:0]),
      .count       (count[i]),
      .phase       (phase[i]),
      .boundary    (bnd[i]),
      .step_last   (last[i])
    );
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        tcon_reg[i]   <= `RST_TCON;
        period_reg[i] <= `RST_PERIOD;
      end else if (ce) begin
        if (wr_tcon[i]) begin
          tcon_reg[i] <= hwdata[6:0];
        end
        if (wr_period[i]) begin
          period_reg[i] <= hwdata[7:0];
        end
      end
    end
    always_ff @(posedge clk) begin
      if (!reset_n) begin
        flag_reg[i] <= 1'b0;
      end else if (ce) begin
        flag_reg[i] <= bnd[i] | (flag_reg[i] & ~(wr_flags & hwdata[i]));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Time base selection
  logic [1:0] sel;
  byte_t      count_sel;
  byte_t      period_sel;
  duty_t      time_base;
  duty_t      duty_active;
  duty_t      duty_staged;
  logic       boundary;
  logic       step_sel;

  assign sel         = (tsel_reg < 2'(NT)) ? tsel_reg : 2'h0;
  assign count_sel   = count[sel];
  assign period_sel  = period_reg[sel];
  assign time_base   = {count_sel, phase[sel]};
  assign boundary    = bnd[sel];
  assign step_sel    = last[sel];
  assign duty_active = {active_reg, latch_reg};
  assign duty_staged = {staging_reg, control_reg[`FLD_DUTY_LOW_HI:`FLD_DUTY_LOW_LO]};

  //////////////////////////////////////////////////////////////////////////////
  // Control and duty registers
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      control_reg <= `RST_CONTROL;
      staging_reg <= `RST_BYTE;
      tsel_reg    <= 2'h0;
      dir_reg     <= `RST_DIRECTION;
    end else if (ce) begin
      if (wr_control) begin
        control_reg <= hwdata[5:0];
      end
      if (wr_staging) begin
        staging_reg <= hwdata[7:0];
      end
      if (wr_tsel) begin
        tsel_reg <= hwdata[1:0];
      end
      if (wr_dir) begin
        dir_reg <= hwdata[0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      active_reg <= `RST_BYTE;
      latch_reg  <= 2'h0;
    end else if (ce) begin
      if (pwm_on && boundary) begin
        active_reg <= staging_reg;
        latch_reg  <= control_reg[`FLD_DUTY_LOW_HI:`FLD_DUTY_LOW_LO];
      end else if (wr_active && !pwm_on) begin
        active_reg <= hwdata[7:0];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin output
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pwm_output_pin <= 1'b0;
      pin_oe_n       <= 1'b1;
    end else if (ce) begin
      pin_oe_n <= !(pwm_on && !dir_reg);
      if (!pwm_on) begin
        pwm_output_pin <= 1'b0;
      end else if (boundary) begin
        pwm_output_pin <= duty_staged != 10'h000;
      end else if (step_sel && (time_base + 10'h001 == duty_active)) begin
        // Decided one cycle early so the pin is low while the base equals duty
        pwm_output_pin <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    rdata = 32'h0000_0000;
    if (acc_rd) begin
      unique case (acc_addr)
        `OFS_MODULE_CONTROL: rdata = {26'h0, control_reg};
        `OFS_DUTY_STAGING:   rdata = {24'h0, staging_reg};
        `OFS_ACTIVE_DUTY:    rdata = {24'h0, active_reg};
        `OFS_TIMER_SELECT:   rdata = {30'h0, tsel_reg};
        `OFS_IRQ_FLAGS:      rdata = {29'h0, flag_reg};
        `OFS_PIN_DIRECTION:  rdata = {31'h0, dir_reg};
        default: begin
          for (int i = 0; i < NT; i++) begin
            if (acc_addr == `OFS_TIMER_CONTROL0 + AW'(i * 4)) rdata = {25'h0, tcon_reg[i]};
            if (acc_addr == `OFS_PERIOD0 + AW'(i * 4))        rdata = {24'h0, period_reg[i]};
            if (acc_addr == `OFS_TIMER_COUNT0 + AW'(i * 4))   rdata = {24'h0, count[i]};
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  chk_pin_release: assert property (@(posedge clk) disable iff (!reset_n)
    (control_reg == 6'h00 && ce) |=> pin_oe_n)
    else $error("pin not released with control zero");

  chk_dir_gate: assert property (@(posedge clk) disable iff (!reset_n)
    (dir_reg && ce) |=> pin_oe_n)
    else $error("pin driven while direction is input");

  chk_duty_latch: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && boundary && ce) |=> duty_active == $past(duty_staged))
    else $error("duty not latched at boundary");

  chk_zero_duty: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && boundary && ce && duty_staged == 10'h000) |=> !pwm_output_pin)
    else $error("pin set with zero duty");

  chk_period_set: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && boundary && ce && duty_staged != 10'h000) |=> pwm_output_pin)
    else $error("pin not set at period start");

  chk_match_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && ce && !boundary && step_sel && time_base + 10'h001 == duty_active)
    |=> !pwm_output_pin)
    else $error("pin not cleared on duty match");

  chk_sleep_hold: assert property (@(posedge clk) disable iff (!reset_n)
    !ce |=> $stable(pwm_output_pin) && $stable(count[0]) && $stable(pin_oe_n))
    else $error("state moved during sleep");

  chk_timer_wrap: assert property (@(posedge clk) disable iff (!reset_n)
    (bnd[0] && ce && !wr_count[0]) |=> count[0] == 8'h00)
    else $error("timer not cleared after period match");

  chk_active_ro: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && wr_active && !boundary) |=> $stable(active_reg))
    else $error("active duty written in pwm mode");

  chk_flag_set: assert property (@(posedge clk) disable iff (!reset_n)
    (bnd[0] && ce) |=> flag_reg[0])
    else $error("match flag not set");

  chk_long_duty: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && ce && !boundary && pwm_output_pin && duty_active > {period_sel, 2'h3})
    |=> pwm_output_pin)
    else $error("pin cleared with duty beyond period");

  chk_mode_off_low: assert property (@(posedge clk) disable iff (!reset_n)
    (!pwm_on && ce) |=> !pwm_output_pin)
    else $error("pin high outside pwm mode");

  chk_mode_off_oe: assert property (@(posedge clk) disable iff (!reset_n)
    (!pwm_on && ce) |=> pin_oe_n)
    else $error("pin driven outside pwm mode");

  chk_oe_follow: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && !dir_reg && ce) |=> !pin_oe_n)
    else $error("pin not driven with direction output");

  chk_pin_low_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && ce && !boundary && !pwm_output_pin) |=> !pwm_output_pin)
    else $error("pin rose inside a period");

  chk_pin_high_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && ce && !boundary && pwm_output_pin &&
     !(step_sel && time_base + 10'h001 == duty_active)) |=> pwm_output_pin)
    else $error("pin fell before duty match");

  chk_active_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (pwm_on && ce && !boundary) |=> $stable(duty_active))
    else $error("active duty moved inside a period");

  chk_latch_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && !(pwm_on && boundary)) |=> $stable(latch_reg))
    else $error("duty low latch moved off boundary");

  chk_staging_write: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && wr_staging) |=> staging_reg == $past(hwdata[7:0]))
    else $error("staging write lost");

  chk_tsel_write: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && wr_tsel) |=> tsel_reg == $past(hwdata[1:0]))
    else $error("timer select write lost");

  chk_period_write: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && wr_period[0]) |=> period_reg[0] == $past(hwdata[7:0]))
    else $error("period write lost");

  chk_timer_hold: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && !tcon_reg[0][`FLD_TIMER_RUN] && !wr_count[0]) |=> $stable(count[0]))
    else $error("stopped timer moved");

  chk_flag_clear: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && wr_flags && hwdata[0] && !bnd[0]) |=> !flag_reg[0])
    else $error("match flag not cleared");

  chk_bus_wait: assert property (@(posedge clk) disable iff (!reset_n)
    (ce && hsel && htrans[1] && hready && hreadyout) |=> !hreadyout)
    else $error("no wait state after address phase");

  cov_full_pulse: cover property (@(posedge clk) disable iff (!reset_n)
    pwm_on && boundary && duty_staged != 10'h000 ##[1:300] !pwm_output_pin);
  cov_zero_duty: cover property (@(posedge clk) disable iff (!reset_n)
    pwm_on && boundary && duty_staged == 10'h000);
  cov_sleep: cover property (@(posedge clk) disable iff (!reset_n)
    pwm_on && !ce ##1 ce);
  cov_pin_on: cover property (@(posedge clk) disable iff (!reset_n)
    !pin_oe_n && pwm_output_pin);
  cov_long_duty: cover property (@(posedge clk) disable iff (!reset_n)
    pwm_on && boundary && duty_staged > {period_sel, 2'h3});

endmodule // standard_pwm_generator

// File: rtl/pwm_defs.svh
// Register map, field positions, reset values and timing counts of the PWM block
`ifndef PWM_DEFS_SVH
`define PWM_DEFS_SVH
`define OFS_MODULE_CONTROL 8'h00
`define OFS_DUTY_STAGING   8'h04
`define OFS_ACTIVE_DUTY    8'h08
`define OFS_TIMER_SELECT   8'h0c
`define OFS_TIMER_CONTROL0 8'h10
`define OFS_PERIOD0        8'h1c
`define OFS_TIMER_COUNT0   8'h28
`define OFS_IRQ_FLAGS      8'h34
`define OFS_PIN_DIRECTION  8'h38
`define OFS_STRIDE         8'h04
`define FLD_MODE_HI        3
`define FLD_MODE_LO        2
`define FLD_DUTY_LOW_HI    5
`define FLD_DUTY_LOW_LO    4
`define FLD_TIMER_RUN      2
`define MODE_PWM_CODE      2'h3
`define RST_CONTROL        6'h00
`define RST_BYTE           8'h00
`define RST_PERIOD         8'hff
`define RST_TCON           7'h00
`define RST_DIRECTION      1'b1
`define PS_LIMIT_1         6'h03
`define PS_LIMIT_4         6'h0f
`define PS_LIMIT_16        6'h3f
`endif

// File: rtl/pwm_pkg.sv
// Types shared by the PWM block
package pwm_pkg;
  typedef logic [7:0] byte_t;
  typedef logic [9:0] duty_t;
  typedef enum logic [1:0] {PS_1, PS_4, PS_16, PS_16_ALT} prescale_t;
  typedef enum logic {BUS_IDLE, BUS_DATA} bus_state_t;
endpackage

// File: rtl/period_timer.sv
// One 8-bit period timer with prescaler and 2-bit phase output
`timescale 1ns/1ns
`include "pwm_defs.svh"
module period_timer #(
  parameter int CW = 8
) (
  // Clock and control
  input  wire logic                clk,
  input  wire logic                reset_n,
  input  wire logic                ce,
  input  wire logic                run,
  input  wire pwm_pkg::prescale_t  prescale,
  input  wire logic [CW-1:0]       period,
  // Software access to the count
  input  wire logic                count_wr,
  input  wire logic [CW-1:0]       count_wdata,
  // Time base
  output logic [CW-1:0]            count,
  output logic [1:0]               phase,
  output logic                     boundary,
  output logic                     step_last
);
  import pwm_pkg::*;
  logic [5:0] div_reg;
  logic [5:0] limit;
  logic       tick;
  always_comb begin
    unique case (prescale)
      PS_1:    limit = `PS_LIMIT_1;
      PS_4:    limit = `PS_LIMIT_4;
      default: limit = `PS_LIMIT_16;
    endcase
  end
  always_comb begin
    unique case (prescale)
      PS_1:    phase = div_reg[1:0];
      PS_4:    phase = div_reg[3:2];
      default: phase = div_reg[5:4];
    endcase
  end
  assign tick     = run && (div_reg == limit);
  assign boundary = tick && (count == period);
  assign step_last = run && ((div_reg & (limit >> 2)) == (limit >> 2));
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      div_reg <= 6'h00;
      count   <= {CW{1'b0}};
    end else if (ce) begin
      if (count_wr) begin
        div_reg <= 6'h00;
        count   <= count_wdata;
      end else if (run) begin
        div_reg <= tick ? 6'h00 : div_reg + 6'h01;
        if (boundary) begin
          count <= {CW{1'b0}};
        end else if (tick) begin
          count <= count + {{(CW-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // period_timer

// File: rtl/ahb_word_port.sv
// AHB-Lite slave front end with one wait state and registered read data
`timescale 1ns/1ns
module ahb_word_port #(
  parameter int AW = 8
) (
  // Clock and control
  input  wire logic          clk,
  input  wire logic          reset_n,
  input  wire logic          ce,
  // AHB-Lite
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic [31:0]        hrdata,
  output logic               hresp,
  // Register access
  output logic               acc_wr,
  output logic               acc_rd,
  output logic [AW-1:0]      acc_addr,
  input  wire logic [31:0]   rdata
);
  import pwm_pkg::*;
  bus_state_t state_reg;
  logic       write_reg;
  assign acc_wr = (state_reg == BUS_DATA) && write_reg;
  assign acc_rd = (state_reg == BUS_DATA) && !write_reg;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= BUS_IDLE;
      write_reg <= 1'b0;
      acc_addr  <= {AW{1'b0}};
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else if (ce) begin
      unique case (state_reg)
        BUS_IDLE: begin
          if (hsel && htrans[1] && hready) begin
            state_reg <= BUS_DATA;
            write_reg <= hwrite;
            acc_addr  <= haddr[AW-1:0];
            hreadyout <= 1'b0;
          end
        end
        BUS_DATA: begin
          if (!write_reg) begin
            hrdata <= rdata;
          end
          state_reg <= BUS_IDLE;
          hreadyout <= 1'b1;
        end
      endcase
    end
  end
endmodule // ahb_word_port

// File: bench/pwm_load_model.sv
// Switched power load that integrates the time it is powered by the pin
`timescale 1ns/1ns
module pwm_load_model (
  // Clock and window clear
  input  wire logic   clk,
  input  wire logic   clr,
  // Pin as seen by the load
  input  wire logic   pin,
  input  wire logic   pin_oe_n,
  // Powered time in clocks
  output logic [15:0] energy
);
  logic powered;

  // Released pin is pulled down at the load
  assign powered = !pin_oe_n && pin;

  always_ff @(posedge clk) begin
    if (clr) begin
      energy <= 16'h0000;
    end else if (powered) begin
      energy <= energy + 16'h0001;
    end
  end
endmodule // pwm_load_model

// File: bench/tb_top.sv
// Self-checking bench for the standard PWM generator
`timescale 1ns/1ns
`include "pwm_defs.svh"
module tb_top;
  import pwm_pkg::*;
  logic        clk, reset_n, ce, hsel, hwrite, clr, held;
  logic [31:0] haddr, hwdata, q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  wire         hready, pin, oe_n, hresp;
  wire  [31:0] hrdata;
  wire  [15:0] energy;
  int          errors, checked;
  logic [7:0]  ra [12] = '{`OFS_MODULE_CONTROL, `OFS_DUTY_STAGING, `OFS_ACTIVE_DUTY,
                           `OFS_TIMER_SELECT, `OFS_TIMER_CONTROL0, `OFS_PERIOD0,
                           8'h20, 8'h24, `OFS_TIMER_COUNT0, `OFS_IRQ_FLAGS,
                           `OFS_PIN_DIRECTION, 8'h3c};
  logic [31:0] rv [12] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'hff, 32'hff, 32'hff,
                           32'h0, 32'h0, 32'h1, 32'h0};
  int          ct [7][4] = '{'{0, 0, 0, 2}, '{1, 1, 1, 3}, '{2, 2, 2, 5}, '{0, 0, 0, 0},
                             '{0, 0, 0, 9}, '{1, 255, 0, 1022}, '{0, 1, 1, 6}};

  standard_pwm_generator standard_pwm_generator_i (
    .clk(clk), .reset_n(reset_n), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hready), .hrdata(hrdata), .hresp(hresp),
    .pwm_output_pin(pin), .pin_oe_n(oe_n));

  pwm_load_model pwm_load_model_i (
    .clk(clk), .clr(clr), .pin(pin), .pin_oe_n(oe_n), .energy(energy));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One AHB single transfer; read data left in q
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 64);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hready !== 1'b1 && n < 64);
    q = hrdata;
    if (n >= 64) begin
      errors++;
      stop_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
    chk(32'(hresp), 32'h0);
  endtask

  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask

  function automatic int psv(input int p);
    return (p == 0) ? 1 : ((p == 1) ? 4 : 16);
  endfunction

  // Setup in the recommended order, then measure on-time over two periods
  task automatic run_case(input int t, input int per, input int ps, input int duty);
    int p, n;
    logic [7:0] tc;
    p = (per + 1) * 4 * psv(ps);
    tc = `OFS_TIMER_CONTROL0 + 8'(4 * t);
    wr(`OFS_PIN_DIRECTION, 32'h1);
    wr(tc, 32'h0);
    wr(`OFS_TIMER_COUNT0 + 8'(4 * t), 32'h0);
    wr(`OFS_PERIOD0 + 8'(4 * t), 32'(per));
    wr(`OFS_MODULE_CONTROL, 32'({duty[1:0], 4'hc}));
    wr(`OFS_DUTY_STAGING, 32'(duty[9:2]));
    wr(`OFS_TIMER_SELECT, 32'(t));
    wr(`OFS_IRQ_FLAGS, 32'h7);
    wr(tc, 32'({4'hf, 1'b1, 2'(ps)}));
    n = 0;
    q = 32'h0;
    while (q[t] !== 1'b1 && n < 3000) begin xfer(1'b0, `OFS_IRQ_FLAGS, 32'h0); n++; end
    if (n >= 3000) begin
      errors++;
      stop_test();
    end
    chk(32'(q[t]), 32'h1);
    wr(`OFS_PIN_DIRECTION, 32'h0);
    repeat (2 * p) @(posedge clk);
    chk(32'(oe_n), 32'h0);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    repeat (2 * p) @(posedge clk);
    #1 chk(32'(energy), 32'(2 * ((duty * psv(ps) < p) ? duty * psv(ps) : p)));
    @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    clr = 1'b0;
    errors = 0;
    checked = 0;
    do_reset();
    for (int i = 0; i < 12; i++) begin
      rd_chk(ra[i], rv[i]);
    end
    $display("test reset_values done");
    for (int i = 0; i < 7; i++) begin
      run_case(ct[i][0], ct[i][1], ct[i][2], ct[i][3]);
    end
    $display("test waveforms done");
    wr(`OFS_TIMER_CONTROL0, 32'h0);
    wr(`OFS_DUTY_STAGING, 32'h5a);
    rd_chk(`OFS_ACTIVE_DUTY, 32'h1);
    wr(`OFS_ACTIVE_DUTY, 32'h33);
    rd_chk(`OFS_ACTIVE_DUTY, 32'h1);
    wr(`OFS_TIMER_CONTROL0, 32'h5);
    repeat (40) @(posedge clk);
    rd_chk(`OFS_ACTIVE_DUTY, 32'h5a);
    $display("test duty_latch done");
    ce <= 1'b0;
    repeat (2) @(posedge clk);
    #1 held = pin;
    repeat (30) @(posedge clk);
    #1 chk(32'(pin), 32'(held));
    @(posedge clk);
    ce <= 1'b1;
    $display("test sleep done");
    wr(`OFS_MODULE_CONTROL, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'(oe_n), 32'h1);
    $display("test release done");
    wr(`OFS_MODULE_CONTROL, 32'h0c);
    do_reset();
    chk(32'(oe_n), 32'h1);
    rd_chk(`OFS_PERIOD0, 32'h0ff);
    rd_chk(`OFS_DUTY_STAGING, 32'h0);
    $display("test mid_reset done");
    stop_test();
  end
endmodule // tb_top
